// File: shared/eirq_params.svh
// eirq_params.svh: offsets, field positions, reset values and vector addresses
// assumes inclusion by bare name from package and design files
`ifndef EIRQ_PARAMS_SVH
`define EIRQ_PARAMS_SVH

`define EIRQ_ADDR_W          4
`define EIRQ_OFF_CTRL        4'h0
`define EIRQ_OFF_ENABLE      4'h1
`define EIRQ_OFF_FLAGS       4'h2
`define EIRQ_OFF_MASK_LOW    4'h3
`define EIRQ_OFF_MASK_HIGH   4'h4
`define EIRQ_OFF_STATUS      4'h5

`define EIRQ_SENSE_HI_BIT    7
`define EIRQ_SENSE_LO_BIT    6
`define EIRQ_EN_GLOBAL_BIT   7
`define EIRQ_EN_PCH_BIT      5
`define EIRQ_EN_PCL_BIT      4
`define EIRQ_EN_EXT_BIT      0
`define EIRQ_FLAG_PCH_BIT    5
`define EIRQ_FLAG_PCL_BIT    4
`define EIRQ_FLAG_EXT_BIT    0
`define EIRQ_REG_RESET       8'h00

`define EIRQ_SENSE_LOW       2'h0
`define EIRQ_SENSE_ANY       2'h1
`define EIRQ_SENSE_FALL      2'h2
`define EIRQ_SENSE_RISE      2'h3

`define EIRQ_VEC_RESET       5'h00
`define EIRQ_VEC_EXT         5'h01
`define EIRQ_VEC_PCL         5'h02
`define EIRQ_VEC_PCH         5'h03
`define EIRQ_VEC_WDT         5'h04
`define EIRQ_VEC_T16_CAPT    5'h05
`define EIRQ_VEC_LAST        5'h10
`define EIRQ_NUM_SRC         17

// start-up time in ns and derived cycles at 25 MHz, longest-time rounding down
`define EIRQ_STARTUP_NS      1000
`define EIRQ_CLK_NS          40
`define EIRQ_STARTUP_CYC     (`EIRQ_STARTUP_NS / `EIRQ_CLK_NS)

`endif

// File: shared/eirq_pkg.sv
// eirq_pkg.sv: types shared by the interrupt block
// assumes eirq_params.svh is on the include path
`include "eirq_params.svh"
package eirq_pkg;
    typedef logic [1:0] eirq_sense_t;
    typedef logic [4:0] eirq_vec_t;
    typedef enum logic [1:0] {
        EIRQ_RUN,
        EIRQ_SLEEP,
        EIRQ_STARTUP
    } eirq_pwr_t;
endpackage

// File: shared/eirq_pin_if.sv
// eirq_pin_if.sv: synchronised pin samples passed from the sampler to the top
// assumes one clock domain, i_sys_clk
`timescale 1ns/1ps
`default_nettype none
interface eirq_pin_if #(parameter int N = 13);
    logic [N-1:0] level;
    logic [N-1:0] changed;
    modport src (output level, output changed);
    modport dst (input level, input changed);
endinterface
`default_nettype wire

// File: design/eirq_pin_sync.sv
// eirq_pin_sync.sv: three-stage sampler per pin with change detection
// assumes asynchronous pins; a change counts when stages two and three disagree
`timescale 1ns/1ps
`default_nettype none
module eirq_pin_sync #(
    parameter int N = 13
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    // pins
    input  wire logic [N-1:0] i_pins,
    eirq_pin_if.src           pins
);
    logic [N-1:0] s1_q, s2_q, s3_q;
    logic [N-1:0] s1_d, s2_d, s3_d;

    always_comb begin
        s1_d = s1_q;
        s2_d = s2_q;
        s3_d = s3_q;
        if (i_ce) begin
            s1_d = i_pins;
            s2_d = s1_q;
            s3_d = s2_q;
        end
    end

    // pins idle high through pull-ups, so reset to ones
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    genvar g;
    for (g = 0; g < N; g++) begin : g_bit
        assign pins.level[g]   = s3_q[g];
        assign pins.changed[g] = s2_q[g] ^ s3_q[g];
    end
endmodule
`default_nettype wire

// File: design/eirq_ctrl.sv
// eirq_ctrl.sv: external request pin and pin-change interrupt logic with vector map
// assumes a plain register port and a core that acknowledges the vector it takes
//
// Notes on behaviour
// - reset vector is address zero for every reset cause
// - external pin vectors to 0x0001, low pin-change group to 0x0002
// - high pin-change group vectors to 0x0003, watchdog to 0x0004
// - 16-bit timer capture, compare A, compare B, overflow at 0x0005..0x0008
// - 8-bit timer compare A, compare B, overflow at 0x0009..0x000b
// - comparator, ADC, two-wire, SPI, touch request at 0x000c..0x0010
// - pins raise interrupts even while configured as outputs
// - enabled toggle on lines 7..0 raises the low group request
// - enabled toggle on lines 11..8 raises the high group request
// - per-pin masks per group; masked lines never trigger
// - pin-change detection works while the core clock sleeps
// - external pin senses falling edge, rising edge or low level
// - low-level mode requests continuously while the pin stays low
// - edge sensing needs the running clock
// - low-level detection wakes from any sleep mode
// - low-level wake takes the interrupt only if still low after start-up
// - level gone before wake-up: resume after sleep, no vector
// - sense field: 00 low, 01 any change, 10 falling, 11 rising
// - flags set on event, clear on vector or write-one; ext flag clear in level
// - pins sampled before edge detection; pulses over one clock are caught
// - ext and pin-change requests taken only with their enable and the global enable set; other sources need only the global enable
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "eirq_params.svh"
module eirq_ctrl #(
    parameter int STARTUP_CYC = `EIRQ_STARTUP_CYC
) (
    // clock, reset, enable
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_ce,
    // pins
    input  wire logic        i_ext_request_pin,
    input  wire logic [11:0] i_pin_change_line,
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    // other sources, vectors 0x0004..0x0010
    input  wire logic [12:0] i_periph_irq,
    // core side
    input  wire logic        i_sleep,
    input  wire logic        i_vec_ack,
    output logic             o_irq,
    output logic [4:0]       o_vector,
    output logic             o_wake,
    output logic [4:0]       o_reset_vector
);
    eirq_pin_if #(.N(13)) pins ();

    eirq_pin_sync #(.N(13)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_pins    ({i_ext_request_pin, i_pin_change_line}),
        .pins      (pins)
    );

    logic [7:0] ctrl_q, ctrl_d, en_q, en_d, mlo_q, mlo_d, mhi_q, mhi_d;
    logic       fext_q, fext_d, fpcl_q, fpcl_d, fpch_q, fpch_d;
    logic [7:0] rdata_q, rdata_d;
    logic [4:0] vec_q, vec_d;
    logic       irq_q, irq_d;
    eirq_pkg::eirq_pwr_t pwr_q, pwr_d;
    logic [15:0] cnt_q, cnt_d;

    eirq_pkg::eirq_sense_t sense;
    logic ext_lvl, ext_chg, ext_event, pcl_event, pch_event, level_mode;
    logic ext_pend, pcl_pend, pch_pend, glob;
    logic [16:0] pend;
    logic wr_ctrl, wr_en, wr_flags, wr_mlo, wr_mhi;
    logic ack_ext, ack_pcl, ack_pch, level_low_raw;

    assign sense = {ctrl_q[`EIRQ_SENSE_HI_BIT], ctrl_q[`EIRQ_SENSE_LO_BIT]};
    assign level_mode = (sense == `EIRQ_SENSE_LOW);
    assign ext_lvl = pins.level[12];
    assign ext_chg = pins.changed[12];

    // pin samples are taken at the pad regardless of direction
    // edges come from the sampled pin, so the clock must run
    // ext_lvl is the older sample: a fall still shows it high, a rise low
    always_comb begin
        case (sense)
            `EIRQ_SENSE_ANY:  ext_event = ext_chg;
            `EIRQ_SENSE_FALL: ext_event = ext_chg & ext_lvl;
            `EIRQ_SENSE_RISE: ext_event = ext_chg & ~ext_lvl;
            default:          ext_event = 1'b0;
        endcase
    end

    assign pcl_event = |(pins.changed[7:0] & mlo_q);
    assign pch_event = |(pins.changed[11:8] & mhi_q[3:0]);

    // low level requests directly, without a flag
    assign glob     = en_q[`EIRQ_EN_GLOBAL_BIT];
    assign ext_pend = en_q[`EIRQ_EN_EXT_BIT] & (level_mode ? ~ext_lvl : fext_q);
    assign pcl_pend = en_q[`EIRQ_EN_PCL_BIT] & fpcl_q;
    assign pch_pend = en_q[`EIRQ_EN_PCH_BIT] & fpch_q;
    assign pend = glob ? {i_periph_irq, pch_pend, pcl_pend, ext_pend, 1'b0}
                       : 17'h00000;

    assign wr_ctrl  = i_wr && i_addr == `EIRQ_OFF_CTRL;
    assign wr_en    = i_wr && i_addr == `EIRQ_OFF_ENABLE;
    assign wr_flags = i_wr && i_addr == `EIRQ_OFF_FLAGS;
    assign wr_mlo   = i_wr && i_addr == `EIRQ_OFF_MASK_LOW;
    assign wr_mhi   = i_wr && i_addr == `EIRQ_OFF_MASK_HIGH;
    assign ack_ext  = i_vec_ack && irq_q && vec_q == `EIRQ_VEC_EXT;
    assign ack_pcl  = i_vec_ack && irq_q && vec_q == `EIRQ_VEC_PCL;
    assign ack_pch  = i_vec_ack && irq_q && vec_q == `EIRQ_VEC_PCH;

    // asynchronous wake paths: raw pin levels, no clock needed
    assign level_low_raw = en_q[`EIRQ_EN_EXT_BIT] & level_mode & ~i_ext_request_pin;
    assign o_wake = (pwr_q == eirq_pkg::EIRQ_SLEEP) &
                    (level_low_raw |
                     |((i_pin_change_line ^ {pins.level[11:0]}) &
                       {mhi_q[3:0], mlo_q}));
    assign o_reset_vector = `EIRQ_VEC_RESET;

    always_comb begin
        ctrl_d = ctrl_q;
        en_d   = en_q;
        mlo_d  = mlo_q;
        mhi_d  = mhi_q;
        fext_d = fext_q;
        fpcl_d = fpcl_q;
        fpch_d = fpch_q;
        if (wr_ctrl) ctrl_d = {i_wdata[7:6], 6'h00};
        if (wr_en)   en_d   = i_wdata & 8'hb1;
        if (wr_mlo)  mlo_d  = i_wdata;
        if (wr_mhi)  mhi_d  = {4'h0, i_wdata[3:0]};
        // write-one or vector clears, a same-cycle event wins
        if ((wr_flags && i_wdata[`EIRQ_FLAG_EXT_BIT]) || ack_ext) fext_d = 1'b0;
        if ((wr_flags && i_wdata[`EIRQ_FLAG_PCL_BIT]) || ack_pcl) fpcl_d = 1'b0;
        if ((wr_flags && i_wdata[`EIRQ_FLAG_PCH_BIT]) || ack_pch) fpch_d = 1'b0;
        if (ext_event) fext_d = 1'b1;
        if (pcl_event) fpcl_d = 1'b1;
        if (pch_event) fpch_d = 1'b1;
        if (level_mode) fext_d = 1'b0;
    end

    // power tracking: level wake must survive start-up
    always_comb begin
        pwr_d = pwr_q;
        cnt_d = cnt_q;
        case (pwr_q)
            eirq_pkg::EIRQ_RUN: begin
                if (i_sleep) pwr_d = eirq_pkg::EIRQ_SLEEP;
            end
            eirq_pkg::EIRQ_SLEEP: begin
                if (!i_sleep || o_wake) begin
                    pwr_d = eirq_pkg::EIRQ_STARTUP;
                    cnt_d = 16'(STARTUP_CYC);
                end
            end
            eirq_pkg::EIRQ_STARTUP: begin
                if (cnt_q <= 16'h0001) pwr_d = eirq_pkg::EIRQ_RUN;
                else cnt_d = cnt_q - 16'h0001;
            end
            default: pwr_d = eirq_pkg::EIRQ_RUN;
        endcase
    end

    // priority: lowest vector first; masked while asleep or starting up
    always_comb begin
        irq_d = 1'b0;
        vec_d = vec_q;
        if (pwr_q == eirq_pkg::EIRQ_RUN && !(i_vec_ack && irq_q)) begin
            for (int k = `EIRQ_NUM_SRC - 1; k >= 1; k--) begin
                if (pend[k]) begin
                    irq_d = 1'b1;
                    vec_d = 5'(k);
                end
            end
        end
    end

    always_comb begin
        case (i_addr)
            `EIRQ_OFF_CTRL:      rdata_d = ctrl_q;
            `EIRQ_OFF_ENABLE:    rdata_d = en_q;
            `EIRQ_OFF_FLAGS:     rdata_d = {2'h0, fpch_q, fpcl_q, 3'h0, fext_q};
            `EIRQ_OFF_MASK_LOW:  rdata_d = mlo_q;
            `EIRQ_OFF_MASK_HIGH: rdata_d = mhi_q;
            `EIRQ_OFF_STATUS:    rdata_d = {3'h0, ext_lvl, 2'(pwr_q), 1'b0, irq_q};
            default:             rdata_d = 8'h00;
        endcase
        if (!i_rd) rdata_d = 8'h00;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q  <= `EIRQ_REG_RESET;
            en_q    <= `EIRQ_REG_RESET;
            mlo_q   <= `EIRQ_REG_RESET;
            mhi_q   <= `EIRQ_REG_RESET;
            fext_q  <= 1'b0;
            fpcl_q  <= 1'b0;
            fpch_q  <= 1'b0;
            rdata_q <= 8'h00;
            vec_q   <= `EIRQ_VEC_RESET;
            irq_q   <= 1'b0;
            pwr_q   <= eirq_pkg::EIRQ_RUN;
            cnt_q   <= 16'h0000;
        end else if (i_ce) begin
            ctrl_q  <= ctrl_d;
            en_q    <= en_d;
            mlo_q   <= mlo_d;
            mhi_q   <= mhi_d;
            fext_q  <= fext_d;
            fpcl_q  <= fpcl_d;
            fpch_q  <= fpch_d;
            rdata_q <= rdata_d;
            vec_q   <= vec_d;
            irq_q   <= irq_d;
            pwr_q   <= pwr_d;
            cnt_q   <= cnt_d;
        end
    end

    assign o_rdata  = rdata_q;
    assign o_irq    = irq_q;
    assign o_vector = vec_q;

    property p_pcl_set;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && pcl_event |=> fpcl_q;
    endproperty
    a_pcl_set: assert property (p_pcl_set) else $error("low group flag missed");

    property p_pch_set;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && pch_event |=> fpch_q;
    endproperty
    a_pch_set: assert property (p_pch_set) else $error("high group flag missed");

    property p_mask;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && !fpcl_q && !pcl_event && !(i_wr && i_addr == `EIRQ_OFF_FLAGS) |=> !fpcl_q;
    endproperty
    a_mask: assert property (p_mask) else $error("low group flag set without cause");

    property p_level_flag;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && level_mode |=> !fext_q;
    endproperty
    a_level_flag: assert property (p_level_flag) else $error("ext flag set in level");

    property p_level_req;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && glob && level_mode && en_q[0] && !ext_lvl && pwr_q == eirq_pkg::EIRQ_RUN
        && !i_vec_ack && !irq_q |=> irq_q && vec_q <= `EIRQ_VEC_EXT;
    endproperty
    a_level_req: assert property (p_level_req) else $error("level request lost");

    property p_gate;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        !glob && i_ce |=> !irq_q;
    endproperty
    a_gate: assert property (p_gate) else $error("irq without global enable");

    property p_prio;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && pwr_q == eirq_pkg::EIRQ_RUN && pend[1] && !(i_vec_ack && irq_q)
        |=> vec_q == `EIRQ_VEC_EXT;
    endproperty
    a_prio: assert property (p_prio) else $error("priority order wrong");

    property p_startup;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        pwr_q != eirq_pkg::EIRQ_RUN |=> !irq_q;
    endproperty
    a_startup: assert property (p_startup) else $error("irq during sleep or start-up");

    property p_rise;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_ce && sense == `EIRQ_SENSE_RISE && ext_chg && !ext_lvl |=> fext_q;
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed");
endmodule
`default_nettype wire

// File: dv/eirq_core_model.sv
// eirq_core_model.sv: core side of the interrupt block, takes vectors
// assumes one clock; acks with a one-cycle pulse after i_delay cycles of o_irq
`timescale 1ns/1ps
`default_nettype none
module eirq_core_model (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    // request from block
    input  wire logic       i_irq,
    input  wire logic [4:0] i_vector,
    input  wire logic [3:0] i_delay,
    // answer and record
    output logic            o_vec_ack,
    output logic [4:0]      o_last_vec,
    output logic [7:0]      o_taken
);
    logic [3:0] cnt_q;

    // one idle edge after each ack so a stale o_irq is never taken twice
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_vec_ack  <= 1'b0;
            o_last_vec <= 5'h00;
            o_taken    <= 8'h00;
            cnt_q      <= 4'h0;
        end else if (o_vec_ack) begin
            o_vec_ack <= 1'b0;
            cnt_q     <= 4'h0;
            // the vector is handed over on the edge the block sees the ack
            if (i_irq) begin
                o_last_vec <= i_vector;
                o_taken    <= o_taken + 8'h01;
            end
        end else if (i_irq) begin
            if (cnt_q >= i_delay) begin
                o_vec_ack <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end else begin
            cnt_q <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// File: dv/tb.sv
// tb.sv: self-checking bench for the interrupt block
// assumes eirq_ctrl with a short start-up and the core model beside it
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        i_sys_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        i_ce = 1'b1;
    logic        i_ext_request_pin = 1'b1;
    logic [11:0] i_pin_change_line = 12'hfff;
    logic [3:0]  i_addr = 4'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [12:0] i_periph_irq = 13'h0000;
    logic        i_sleep = 1'b0;
    logic [3:0]  ack_dly = 4'h0;
    wire logic   vec_ack;
    wire logic   o_irq;
    wire logic   o_wake;
    wire logic [7:0] o_rdata;
    wire logic [4:0] o_vector;
    wire logic [4:0] o_reset_vector;
    wire logic [4:0] last_vec;
    wire logic [7:0] taken;
    int          fail_count = 0;
    int          samples_checked = 0;

    eirq_ctrl #(.STARTUP_CYC(8)) DUT (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
        .i_ext_request_pin(i_ext_request_pin), .i_pin_change_line(i_pin_change_line),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_periph_irq(i_periph_irq), .i_sleep(i_sleep), .i_vec_ack(vec_ack),
        .o_irq(o_irq), .o_vector(o_vector), .o_wake(o_wake),
        .o_reset_vector(o_reset_vector));
    eirq_core_model core (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_irq(o_irq), .i_vector(o_vector),
        .i_delay(ack_dly), .o_vec_ack(vec_ack), .o_last_vec(last_vec), .o_taken(taken));

    always #20 i_sys_clk = ~i_sys_clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        chk(nm, e, o_rdata);
    endtask

    task automatic take(input logic [4:0] v);
        int i;
        logic [7:0] t0;
        t0 = taken;
        for (i = 0; i < 100 && taken == t0; i++) @(posedge i_sys_clk);
        if (taken == t0) begin
            fail_count++;
            $display("BAD take expected %h seen none", v);
            end_sim();
        end
        chk("vector", {3'h0, v}, {3'h0, last_vec});
    endtask

    task automatic pc_tog(input int b);
        @(posedge i_sys_clk);
        i_pin_change_line[b] <= ~i_pin_change_line[b];
    endtask

    task automatic ext(input logic v, input int n);
        @(posedge i_sys_clk);
        i_ext_request_pin <= v;
        cyc(n);
    endtask

    task automatic t_reset();
        int a;
        for (a = 0; a < 5; a++) rd("reg reset", 4'(a), 8'h00);
        rd("status", 4'h5, 8'h10);
        rd("unmapped", 4'h6, 8'h00);
        chk("reset vector", 8'h00, {3'h0, o_reset_vector});
        chk("irq idle", 8'h00, {7'h0, o_irq});
        $display("test reset done");
    endtask

    task automatic t_pc();
        logic [7:0] t0;
        wr(4'h3, 8'h01);
        wr(4'h1, 8'h10);
        t0 = taken;
        pc_tog(1);
        cyc(10);
        rd("masked line", 4'h2, 8'h00);
        pc_tog(0);
        cyc(10);
        rd("low flag", 4'h2, 8'h10);
        chk("no global", t0, taken);
        wr(4'h2, 8'h10);
        rd("write one", 4'h2, 8'h00);
        pc_tog(0);
        cyc(10);
        wr(4'h1, 8'h90);
        take(5'h02);
        cyc(3);
        rd("flag by vector", 4'h2, 8'h00);
        ack_dly <= 4'h3;
        wr(4'h4, 8'h08);
        wr(4'h1, 8'ha0);
        pc_tog(11);
        take(5'h03);
        pc_tog(8);
        cyc(10);
        rd("high masked", 4'h2, 8'h00);
        ack_dly <= 4'h0;
        $display("test pin change done");
    endtask

    task automatic t_ext();
        int m;
        logic [7:0] t0;
        for (m = 1; m < 4; m++) begin
            wr(4'h0, {2'(m), 6'h00});
            wr(4'h1, 8'h81);
            t0 = taken;
            // a falling pin must be taken in change and fall modes only
            ext(1'b0, 10);
            chk("fall takes", (m == 3) ? 8'h00 : 8'h01, taken - t0);
            ext(1'b1, 6);
            cyc(10);
            chk("edge takes", (m == 1) ? 8'h02 : 8'h01, taken - t0);
        end
        wr(4'h0, 8'h00);
        t0 = taken;
        ext(1'b0, 40);
        rd("level flag", 4'h2, 8'h00);
        ext(1'b1, 10);
        chk("level repeats", 8'h01, {7'h0, (taken - t0) > 8'h02});
        wr(4'h0, 8'h80);
        t0 = taken;
        @(posedge i_sys_clk);
        i_ce <= 1'b0;
        ext(1'b0, 5);
        ext(1'b1, 5);
        @(posedge i_sys_clk);
        i_ce <= 1'b1;
        cyc(15);
        chk("halted clock", t0, taken);
        $display("test external pin done");
    endtask

    task automatic t_sleep();
        int i;
        logic [7:0] t0;
        wr(4'h0, 8'h00);
        t0 = taken;
        @(posedge i_sys_clk);
        i_sleep <= 1'b1;
        cyc(3);
        @(posedge i_sys_clk);
        i_ext_request_pin <= 1'b0;
        @(negedge i_sys_clk);
        chk("level wake", 8'h01, {7'h0, o_wake});
        @(posedge i_sys_clk);
        i_ext_request_pin <= 1'b1;
        i_sleep <= 1'b0;
        cyc(20);
        chk("short level", t0, taken);
        @(posedge i_sys_clk);
        i_sleep <= 1'b1;
        cyc(3);
        ext(1'b0, 0);
        @(negedge i_sys_clk);
        chk("held wake", 8'h01, {7'h0, o_wake});
        @(posedge i_sys_clk);
        i_sleep <= 1'b0;
        take(5'h01);
        ext(1'b1, 5);
        wr(4'h1, 8'h90);
        @(posedge i_sys_clk);
        i_sleep <= 1'b1;
        cyc(3);
        pc_tog(0);
        for (i = 0; i < 10 && o_wake !== 1'b1; i++) @(negedge i_sys_clk);
        chk("change wake", 8'h01, {7'h0, o_wake});
        @(posedge i_sys_clk);
        i_sleep <= 1'b0;
        take(5'h02);
        $display("test sleep done");
    endtask

    task automatic t_vec();
        int i;
        wr(4'h1, 8'h80);
        for (i = 12; i >= 0; i--) begin
            @(posedge i_sys_clk);
            i_periph_irq <= 13'h0000;
            cyc(8);
            @(posedge i_sys_clk);
            i_periph_irq <= 13'h1fff << i;
            take(5'(i + 4));
        end
        @(posedge i_sys_clk);
        i_periph_irq <= 13'h0000;
        cyc(8);
        $display("test vectors done");
    endtask

    initial begin
        cyc(6);
        i_resetn <= 1'b1;
        t_reset();
        t_pc();
        t_ext();
        t_sleep();
        t_vec();
        end_sim();
    end
endmodule
`default_nettype wire
